// ==== core/sbc_indicator.sv ====
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module sbc_indicator
  import sbc_pkg::*;
#(
  parameter longint unsigned SQUAWK_CYCLES = SQUAWK_CYC,
  parameter int unsigned     FLASH_CYCLES  = FLASH_CYC,
  parameter int unsigned     GAP_CYCLES    = GAP_CYC,
  parameter int unsigned     LOCK_CYCLES   = LOCK_CYC,
  parameter int unsigned     BRIEF_CYCLES  = BRIEF_CYC
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [NCOND-1:0] i_cond,
  input  wire logic [6:0]       i_final_cmd,
  input  wire logic             i_btn_up,
  input  wire logic             i_btn_down,
  input  wire logic             i_btn_accept,
  input  wire logic             i_btn_back,
  input  wire logic             i_cfg_change_req,
  input  wire logic             i_cal_req,
  input  wire logic [7:0]       i_awaddr,
  input  wire logic             i_awvalid,
  output logic                  o_awready,
  input  wire logic [31:0]      i_wdata,
  input  wire logic [3:0]       i_wstrb,
  input  wire logic             i_wvalid,
  output logic                  o_wready,
  output logic [1:0]            o_bresp,
  output logic                  o_bvalid,
  input  wire logic             i_bready,
  input  wire logic [7:0]       i_araddr,
  input  wire logic             i_arvalid,
  output logic                  o_arready,
  output logic [31:0]           o_rdata,
  output logic [1:0]            o_rresp,
  output logic                  o_rvalid,
  input  wire logic             i_rready,
  output logic [1:0]            o_led,
  output logic                  o_full_pressure,
  output logic                  o_full_open,
  output logic                  o_pos_hold,
  output logic                  o_out_of_service,
  output logic                  o_cfg_accept,
  output logic                  o_jog_mode,
  output logic                  o_cal_abort
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // condition index: act bit -> packed code, listed by priority
  // ----------------------------------------------------------------
  function automatic logic [7:0] code_of(input int unsigned n);
    logic [7:0] c;
    c = 8'h00;
    unique case (n)
      0: c = {C_R, C_R, C_R, C_R}; // deviation
      1: c = {C_R, C_R, C_R, C_Y}; // piezo alarms
      2: c = {C_R, C_R, C_Y, C_R}; // driver module
      3: c = {C_R, C_R, C_G, C_G}; // relay response
      4: c = {C_R, C_R, C_Y, C_G}; // linkage
      5: c = {C_R, C_Y, C_R, C_G}; // sensor failure
      6: c = {C_R, C_Y, C_R, C_R}; // board failure
      7: c = {C_R, C_Y, C_Y, C_G}; // supply low
      8: c = {C_R, C_Y, C_G, C_G}; // cannot open/shut
      9: c = {C_R, C_G, C_G, C_G}; // command range
      10: c = {C_R, C_G, C_G, C_Y}; // position range
      11: c = {C_R, C_G, C_G, C_R}; // offset timeout
      12: c = {C_R, C_G, C_Y, C_G}; // settle timeout
      13: c = {C_R, C_G, C_Y, C_Y}; // no motion
      14: c = {C_R, C_G, C_R, C_G}; // cal required
      15: c = {C_R, C_G, C_R, C_Y}; // shift/span
      16: c = {C_R, C_G, C_R, C_R}; // factory reset
      17: c = {C_Y, C_G, C_G, C_G}; // limit alerts
      18: c = {C_Y, C_G, C_G, C_Y}; // cycle/travel
      19: c = {C_Y, C_G, C_R, C_R}; // stroke test failed
      20: c = {C_Y, C_Y, C_G, C_G}; // temperature
      21: c = {C_Y, C_Y, C_G, C_Y}; // too far
      22: c = {C_Y, C_Y, C_Y, C_R}; // memory
      23: c = {C_Y, C_Y, C_R, C_G}; // software
      24: c = {C_Y, C_R, C_G, C_G}; // relay warning
      25: c = {C_Y, C_R, C_R, C_Y}; // piezo warnings
      26: c = {C_G, C_G, C_Y, C_R}; // initializing
      27: c = {C_G, C_R, C_R, C_R}; // jog calibration
      28: c = {C_G, C_R, C_G, C_Y}; // calibration
      29: c = {C_G, C_R, C_G, C_G}; // test running
      30: c = {C_G, C_R, C_R, C_Y}; // jog
      31: c = {C_G, C_G, C_R, C_R}; // squawk
      32: c = {C_G, C_Y, C_G, C_Y}; // soft stop
      33: c = {C_G, C_G, C_Y, C_G}; // locked
      34: c = {C_G, C_G, C_Y, C_Y}; // digital
      35: c = {C_G, C_G, C_G, C_Y}; // tight shutoff
      default: c = {C_G, C_G, C_G, C_G}; // power on
    endcase
    return c;
  endfunction

  // i_cond bits 0..25 are fault inputs; 26..29 status inputs; 30..44 unused.
  // bit 26 jog-cal wait, 27 test run, 28 soft limit hit (high), 29 low

  // ----------------------------------------------------------------
  // pin synchronisers (3 stages, second and third must agree)
  // ----------------------------------------------------------------
  logic [4:0] pin_raw;
  logic [4:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [4:0] pin_q, pin_d;
  assign pin_raw = {i_cfg_change_req, i_btn_back, i_btn_accept,
                    i_btn_down, i_btn_up};
  always_comb begin
    s1_d = pin_raw;
    s2_d = s1_q;
    s3_d = s2_q;
    pin_d = pin_q;
    for (int k = 0; k < 5; k++) begin
      if (s2_q[k] == s3_q[k]) pin_d[k] = s3_q[k];
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      pin_q <= 5'h00;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // brief-press detection: release within BRIEF_CYCLES
  // ----------------------------------------------------------------
  logic [31:0] acc_cnt_q, acc_cnt_d, back_cnt_q, back_cnt_d;
  logic        acc_prev_q, back_prev_q, chg_prev_q;
  logic        acc_brief, back_brief, chg_edge, both_held_q, both_held_d;
  always_comb begin
    acc_cnt_d = pin_q[2] ? ((acc_cnt_q == 32'hFFFFFFFF) ? acc_cnt_q
                : acc_cnt_q + 32'h1) : 32'h0;
    back_cnt_d = pin_q[3] ? ((back_cnt_q == 32'hFFFFFFFF) ? back_cnt_q
                 : back_cnt_q + 32'h1) : 32'h0;
    acc_brief = acc_prev_q && !pin_q[2] && (acc_cnt_q < BRIEF_CYCLES);
    back_brief = back_prev_q && !pin_q[3] && (back_cnt_q < BRIEF_CYCLES);
    chg_edge = pin_q[4] && !chg_prev_q;
    // up+down must be held during the accept press
    both_held_d = pin_q[2] ? (both_held_q & pin_q[0] & pin_q[1])
                  : (pin_q[0] & pin_q[1]);
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_cnt_q <= 32'h0;
      back_cnt_q <= 32'h0;
      acc_prev_q <= 1'b0;
      back_prev_q <= 1'b0;
      chg_prev_q <= 1'b0;
      both_held_q <= 1'b0;
    end else begin
      acc_cnt_q <= acc_cnt_d;
      back_cnt_q <= back_cnt_d;
      acc_prev_q <= pin_q[2];
      back_prev_q <= pin_q[3];
      chg_prev_q <= pin_q[4];
      both_held_q <= both_held_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_fire;
  logic [31:0] ctrl_pulse;
  logic        lock_q, lock_d, upper_q, upper_d;
  logic [6:0]  tso_lo_q, tso_lo_d, tso_hi_q, tso_hi_d;
  logic [5:0]  mode_q;
  logic [7:0]  code_q;

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ctrl_pulse = 32'h0;
    lock_d = lock_q;
    upper_d = upper_q;
    tso_lo_d = tso_lo_q;
    tso_hi_d = tso_hi_q;
    if (i_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = i_awaddr;
    end
    if (i_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      w_data_d = i_wdata;
      w_strb_d = i_wstrb;
    end
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (aw_addr_q)
        A_CTRL: begin
          if (w_strb_q[0]) begin
            ctrl_pulse = w_data_q;
            lock_d = w_data_q[B_LOCK];
            upper_d = w_data_q[B_UPPER_TSO];
          end
        end
        A_TSO: begin
          if (w_strb_q[0]) tso_lo_d = w_data_q[6:0];
          if (w_strb_q[1]) tso_hi_d = w_data_q[14:8];
        end
        A_MODE, A_COND0, A_COND1, A_CODE: ;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && i_bready) bvalid_d = 1'b0;
    if (i_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (i_araddr)
        A_CTRL: rdata_d = {24'h0, upper_q, lock_q, 6'h00};
        A_MODE: rdata_d = {26'h0, mode_q};
        A_COND0: rdata_d = i_cond[31:0];
        A_COND1: rdata_d = {19'h0, i_cond[NCOND-1:32]};
        A_CODE: rdata_d = {24'h0, code_q};
        A_TSO: rdata_d = {17'h0, tso_hi_q, 1'b0, tso_lo_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
      lock_q <= 1'b0;
      upper_q <= 1'b0;
      tso_lo_q <= TSO_LOW_RST;
      tso_hi_q <= 7'h7F;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      lock_q <= lock_d;
      upper_q <= upper_d;
      tso_lo_q <= tso_lo_d;
      tso_hi_q <= tso_hi_d;
    end
  end
  assign o_awready = !aw_have_q;
  assign o_wready = !w_have_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  logic        squawk_q, squawk_d, dig_q, dig_d, jog_q, jog_d;
  logic        cal_q, cal_d, abort_q, abort_d, accept_q, accept_d;
  logic [63:0] sq_cnt_q, sq_cnt_d;
  logic [31:0] lock_cnt_q, lock_cnt_d;
  logic        tso_lo_hit, tso_hi_hit, tso_q, tso_d, hi_q, hi_d;
  logic        init_done;
  logic        oos_q, oos_d, hold_q, hold_d;
  always_comb begin
    squawk_d = squawk_q;
    sq_cnt_d = sq_cnt_q;
    if (ctrl_pulse[B_SQUAWK_ON]) begin
      squawk_d = 1'b1;
      sq_cnt_d = 64'h0;
    end else if (squawk_q) begin
      sq_cnt_d = sq_cnt_q + 64'h1;
      if (acc_brief || ctrl_pulse[B_SQUAWK_OFF] ||
          sq_cnt_q >= SQUAWK_CYCLES - 1) squawk_d = 1'b0;
    end
    dig_d = dig_q;
    if (ctrl_pulse[B_DIGITAL]) dig_d = 1'b1;
    if (ctrl_pulse[B_ANALOG] || (acc_brief && both_held_q))
      dig_d = 1'b0;
    jog_d = jog_q;
    if (ctrl_pulse[B_JOG_ON]) jog_d = 1'b1;
    else if (acc_brief && !both_held_q) jog_d = 1'b0;
    cal_d = cal_q;
    abort_d = 1'b0;
    if (i_cal_req && !cal_q) cal_d = 1'b1;
    else if (cal_q && (back_brief || ctrl_pulse[B_CAL_CANCEL])) begin
      cal_d = 1'b0;
      abort_d = 1'b1;
    end
    // locked: changes refused, code shown briefly
    accept_d = chg_edge && !lock_q;
    lock_cnt_d = (lock_cnt_q != 32'h0) ? lock_cnt_q - 32'h1 : 32'h0;
    if (chg_edge && lock_q) lock_cnt_d = LOCK_CYCLES;
    tso_lo_hit = i_final_cmd < tso_lo_q;
    tso_hi_hit = upper_q && (i_final_cmd > tso_hi_q);
    tso_d = tso_lo_hit || tso_hi_hit;
    hi_d = tso_hi_hit;
    oos_d = cal_d || i_cond[27];
    hold_d = i_cond[28] || i_cond[29];
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      squawk_q <= 1'b0;
      sq_cnt_q <= 64'h0;
      dig_q <= 1'b0;
      jog_q <= 1'b0;
      cal_q <= 1'b0;
      abort_q <= 1'b0;
      accept_q <= 1'b0;
      lock_cnt_q <= 32'h0;
      tso_q <= 1'b0;
      hi_q <= 1'b0;
      oos_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      squawk_q <= squawk_d;
      sq_cnt_q <= sq_cnt_d;
      dig_q <= dig_d;
      jog_q <= jog_d;
      cal_q <= cal_d;
      abort_q <= abort_d;
      accept_q <= accept_d;
      lock_cnt_q <= lock_cnt_d;
      tso_q <= tso_d;
      hi_q <= hi_d;
      oos_q <= oos_d;
      hold_q <= hold_d;
    end
  end

  property p_tso_low;
    i_final_cmd < tso_lo_q |=> tso_q;
  endproperty
  a_tso_low: assert property (p_tso_low) else $error("shutoff");
  property p_tso_hi;
    upper_q && i_final_cmd > tso_hi_q |=> hi_q;
  endproperty
  a_tso_hi: assert property (p_tso_hi) else $error("upper shutoff");
  property p_lock;
    chg_edge && lock_q |=> !accept_q && lock_cnt_q != 32'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("locked change");
  property p_sq_cnt;
    squawk_q |-> sq_cnt_q < SQUAWK_CYCLES;
  endproperty
  a_sq_cnt: assert property (p_sq_cnt) else $error("squawk expiry");
  property p_cal_stop;
    cal_q && back_brief |=> !cal_q && abort_q;
  endproperty
  a_cal_stop: assert property (p_cal_stop) else $error("cancel");

  // ----------------------------------------------------------------
  // priority select and flash sequencer
  // ----------------------------------------------------------------
  logic [35:0] act;
  logic [7:0]  sel;
  logic [1:0]  slot_q, slot_d, seqs_q, seqs_d;
  logic [31:0] tick_q, tick_d;
  logic        gap_q, gap_d;
  logic [1:0]  led_q, led_d;
  assign init_done = (seqs_q == 2'(INIT_SEQS));
  always_comb begin
    act = {tso_q, dig_q, lock_cnt_q != 32'h0, i_cond[28] | i_cond[29],
           squawk_q, jog_q, i_cond[27], cal_q, i_cond[26], !init_done,
           i_cond[25:0]};
    sel = code_of(36);
    for (int k = 35; k >= 0; k--) begin
      if (act[k]) sel = code_of(k);
    end
    slot_d = slot_q;
    seqs_d = seqs_q;
    gap_d = gap_q;
    tick_d = tick_q + 32'h1;
    if (!gap_q && tick_q >= FLASH_CYCLES - 1) begin
      tick_d = 32'h0;
      slot_d = slot_q + 2'h1;
      if (slot_q == 2'h3) gap_d = 1'b1;
    end else if (gap_q && tick_q >= GAP_CYCLES - 1) begin
      tick_d = 32'h0;
      gap_d = 1'b0;
      if (!init_done) seqs_d = seqs_q + 2'h1;
    end
    led_d = gap_d ? 2'h0 : sel[6 - 2 * slot_d +: 2];
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_q <= 2'h0;
      seqs_q <= 2'h0;
      tick_q <= 32'h0;
      gap_q <= 1'b0;
      led_q <= 2'h0;
      code_q <= 8'h00;
    end else begin
      slot_q <= slot_d;
      seqs_q <= seqs_d;
      tick_q <= tick_d;
      gap_q <= gap_d;
      led_q <= led_d;
      code_q <= sel;
    end
  end

  property p_init;
    !init_done && act[25:0] == 26'h0 |-> sel == {C_G, C_G, C_Y, C_R};
  endproperty
  a_init: assert property (p_init) else $error("init code");
  assign mode_q = {lock_q, !init_done, cal_q, jog_q, dig_q, squawk_q};
  assign o_led = led_q;
  assign o_full_pressure = tso_q;
  assign o_full_open = hi_q;
  assign o_pos_hold = hold_q;
  assign o_out_of_service = oos_q;
  assign o_cfg_accept = accept_q;
  assign o_jog_mode = jog_q;
  assign o_cal_abort = abort_q;
endmodule

// ==== pkg/sbc_pkg.sv ====
// Operation
// - three init sequences, then all-green
// - shutoff limit passed gives full pressure, code
// - upper shutoff limit optional, gives full open
// - locked: reject changes, brief locked code
// - digital command source shows its code
// - accept with up and down resets source
// - squawk ends on accept, remote, one hour
// - soft limit holds position, shows code
// - tests put device out of service
// - calibration code, cancel by back or remote
// - jog mode: buttons only, accept exits
// - command input range faults share code
// - position range faults share code
// - three distinct calibration timeout codes
// - stroke required, shift/span, factory reset codes
// - deviation, piezo alarm, driver module codes
// - relay response, linkage, sensor failure codes
// - board failure, supply, cannot open/shut codes
// - limit alerts, cycle warnings, stroke test codes
// - temperature, too far, memory error codes
// - software, relay warning, piezo warning codes
// - jog calibration waiting shows its code
package sbc_pkg;
  typedef enum logic [1:0] {
    SBC_OFF,
    SBC_GRN,
    SBC_YEL,
    SBC_RED
  } sbc_color_t;

  // code packed as four 2-bit colours, first flash in bits 7:6
  localparam logic [1:0] C_G = 2'h1;
  localparam logic [1:0] C_Y = 2'h2;
  localparam logic [1:0] C_R = 2'h3;

  localparam int unsigned NCOND = 45;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned GAP_MS = 1000;
  localparam int unsigned LOCK_MS = 2000;
  localparam int unsigned BRIEF_MS = 1000;
  localparam int unsigned SQUAWK_S = 3600;
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  localparam int unsigned LOCK_CYC = CLK_HZ / 1000 * LOCK_MS;
  localparam int unsigned BRIEF_CYC = CLK_HZ / 1000 * BRIEF_MS;
  localparam longint unsigned SQUAWK_CYC = 64'(CLK_HZ) * SQUAWK_S;
  localparam int unsigned INIT_SEQS = 3;

  // AXI4-Lite register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_COND0 = 8'h08;
  localparam logic [7:0] A_COND1 = 8'h0C;
  localparam logic [7:0] A_CODE = 8'h10;
  localparam logic [7:0] A_TSO = 8'h14;
  // control bits (write-one pulses / levels)
  localparam int unsigned B_SQUAWK_ON = 0;
  localparam int unsigned B_SQUAWK_OFF = 1;
  localparam int unsigned B_DIGITAL = 2;
  localparam int unsigned B_ANALOG = 3;
  localparam int unsigned B_CAL_CANCEL = 4;
  localparam int unsigned B_JOG_ON = 5;
  localparam int unsigned B_LOCK = 6;
  localparam int unsigned B_UPPER_TSO = 7;
  // mode bits
  localparam int unsigned M_SQUAWK = 0;
  localparam int unsigned M_DIGITAL = 1;
  localparam int unsigned M_JOG = 2;
  localparam int unsigned M_CAL = 3;
  localparam int unsigned M_INIT = 4;
  localparam int unsigned M_LOCKED = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [6:0] TSO_LOW_RST = 7'h01;
endpackage

// ==== tb/sbc_host.sv ====
`timescale 1ns/1ns
module sbc_host (
  input  wire logic        i_clock,
  output logic [7:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  // answer delay, raised to mimic a slow host
  int stall = 0;
  initial begin
    o_awaddr  = 8'h00;
    o_awvalid = 1'b0;
    o_wdata   = 32'h0;
    o_wvalid  = 1'b0;
    o_bready  = 1'b0;
    o_araddr  = 8'h00;
    o_arvalid = 1'b0;
    o_rready  = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clock);
    o_awaddr  <= a;
    o_awvalid <= 1'b1;
    o_wdata   <= d;
    o_wvalid  <= 1'b1;
    do begin
      @(posedge i_clock);
      // released payload toggles, so stale values never look valid
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
    end while ((o_awvalid && !i_awready) || (o_wvalid && !i_wready));
    repeat (stall) @(posedge i_clock);
    o_bready <= 1'b1;
    do @(posedge i_clock); while (!(i_bvalid && o_bready));
    r = i_bresp;
    o_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clock);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    do @(posedge i_clock); while (!i_arready);
    o_arvalid <= 1'b0;
    o_araddr  <= ~a;
    repeat (stall) @(posedge i_clock);
    o_rready <= 1'b1;
    do @(posedge i_clock); while (!(i_rvalid && o_rready));
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask
endmodule

// ==== tb/sbc_indicator_bench.sv ====
`timescale 1ns/1ns
module sbc_indicator_bench;
  import sbc_pkg::*;
  logic             i_clock = 1'b0;
  logic             i_rst_n = 1'b0;
  logic [NCOND-1:0] i_cond = '0;
  logic [6:0]       i_final_cmd = 7'd50;
  logic             i_btn_up = 1'b0;
  logic             i_btn_down = 1'b0;
  logic             i_btn_accept = 1'b0;
  logic             i_btn_back = 1'b0;
  logic             i_cfg_change_req = 1'b0;
  logic             i_cal_req = 1'b0;
  logic [7:0]       i_awaddr, i_araddr;
  logic [31:0]      i_wdata, o_rdata;
  logic [3:0]       i_wstrb = 4'hF;
  logic [1:0]       o_bresp, o_rresp, o_led;
  logic             i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic             o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic             o_full_pressure, o_full_open, o_pos_hold;
  logic             o_out_of_service, o_cfg_accept, o_jog_mode;
  logic             o_cal_abort;
  logic [31:0]      d;
  logic [1:0]       r;
  int               bad_count = 0;
  int               checks = 0;
  int               acc_n = 0;
  int               abt_n = 0;

  sbc_indicator #(.SQUAWK_CYCLES(200), .FLASH_CYCLES(4), .GAP_CYCLES(8),
    .LOCK_CYCLES(20), .BRIEF_CYCLES(10)) sbc_indicator_i (.*);
  sbc_host sbc_host_i (.i_clock(i_clock), .o_awaddr(i_awaddr),
    .o_awvalid(i_awvalid), .i_awready(o_awready), .o_wdata(i_wdata),
    .o_wvalid(i_wvalid), .i_wready(o_wready), .i_bresp(o_bresp),
    .i_bvalid(o_bvalid), .o_bready(i_bready), .o_araddr(i_araddr),
    .o_arvalid(i_arvalid), .i_arready(o_arready), .i_rdata(o_rdata),
    .i_rresp(o_rresp), .i_rvalid(o_rvalid), .o_rready(i_rready));

  // ----------------------------------------
  // clock, pulse counters, watchdog
  // ----------------------------------------
  initial begin
    forever #20 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (o_cfg_accept === 1'b1) acc_n++;
    if (o_cal_abort === 1'b1) abt_n++;
  end
  initial begin
    #(40 * 20000);
    bad_count++;
    wrap_up();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic code_is(input logic [7:0] e);
    sbc_host_i.rd(A_CODE, d, r);
    chk("code", {24'h0, d[7:0]}, {24'h0, e});
  endtask
  task automatic ctrl(input logic [7:0] v);
    sbc_host_i.wr(A_CTRL, {24'h0, v}, r);
    tick(4);
  endtask
  // brief press: well under the hold limit, then let sync settle
  task automatic accept_tap();
    i_btn_accept <= 1'b1;
    tick(3);
    i_btn_accept <= 1'b0;
    tick(10);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init();
    code_is(8'h5B);
    tick(200);
    code_is(8'h55);
    sbc_host_i.rd(8'h20, d, r);
    chk("bad addr resp", r, RESP_SLVERR);
    chk("bad addr data", d, 0);
    $display("test init done");
  endtask
  task automatic t_shutoff();
    i_final_cmd <= 7'd0;
    tick(8);
    code_is(8'h56);
    chk("full pressure", o_full_pressure, 1);
    i_final_cmd <= 7'd50;
    sbc_host_i.wr(A_TSO, 32'h0000_5001, r);
    ctrl(8'h80);
    i_final_cmd <= 7'd100;
    tick(8);
    code_is(8'h56);
    chk("full open", o_full_open, 1);
    i_final_cmd <= 7'd50;
    ctrl(8'h00);
    tick(4);
    code_is(8'h55);
    $display("test shutoff done");
  endtask
  task automatic t_source();
    ctrl(8'h04);
    code_is(8'h5A);
    i_btn_up <= 1'b1;
    i_btn_down <= 1'b1;
    tick(5);
    accept_tap();
    i_btn_up <= 1'b0;
    i_btn_down <= 1'b0;
    tick(5);
    sbc_host_i.rd(A_MODE, d, r);
    chk("digital mode", d[M_DIGITAL], 0);
    code_is(8'h55);
    ctrl(8'h04);
    ctrl(8'h08);
    code_is(8'h55);
    $display("test source done");
  endtask
  task automatic t_squawk();
    sbc_host_i.stall = 3;
    for (int k = 0; k < 3; k++) begin
      ctrl(8'h01);
      code_is(8'h5F);
      if (k == 0) accept_tap();
      if (k == 1) ctrl(8'h02);
      if (k == 2) begin
        tick(100);
        code_is(8'h5F);
        tick(100);
      end
      code_is(8'h55);
    end
    sbc_host_i.stall = 0;
    $display("test squawk done");
  endtask
  task automatic t_lock();
    int a0;
    a0 = acc_n;
    ctrl(8'h40);
    i_cfg_change_req <= 1'b1;
    tick(6);
    code_is(8'h59);
    i_cfg_change_req <= 1'b0;
    tick(30);
    code_is(8'h55);
    chk("locked accept", acc_n - a0, 0);
    ctrl(8'h00);
    i_cfg_change_req <= 1'b1;
    tick(8);
    i_cfg_change_req <= 1'b0;
    chk("open accept", acc_n - a0, 1);
    $display("test lock done");
  endtask
  task automatic t_cal();
    int a0;
    a0 = abt_n;
    for (int k = 0; k < 2; k++) begin
      i_cal_req <= 1'b1;
      tick(4);
      i_cal_req <= 1'b0;
      tick(4);
      code_is(8'h76);
      chk("oos", o_out_of_service, 1);
      if (k == 0) begin
        i_btn_back <= 1'b1;
        tick(3);
        i_btn_back <= 1'b0;
        tick(10);
      end else ctrl(8'h10);
      chk("abort", abt_n - a0, k + 1);
      code_is(8'h55);
    end
    $display("test calibration done");
  endtask
  task automatic t_jog();
    ctrl(8'h20);
    code_is(8'h7E);
    chk("jog on", o_jog_mode, 1);
    accept_tap();
    chk("jog off", o_jog_mode, 0);
    $display("test jog done");
  endtask
  task automatic t_faults();
    logic [7:0] ex[26] = '{8'hD5, 8'hD6, 8'hD7, 8'hD9, 8'hDA, 8'hDD,
      8'hDE, 8'hDF, 8'hFF, 8'hFE, 8'hFB, 8'hF5, 8'hF9, 8'hED, 8'hEF,
      8'hE9, 8'hE5, 8'h95, 8'h96, 8'h9F, 8'hA5, 8'hA6, 8'hAB, 8'hAD,
      8'hB5, 8'hBE};
    bit used[26] = '{default: 0};
    bit hit;
    logic [7:0] s;
    logic [1:0] last;
    for (int i = 0; i < 26; i++) begin
      i_cond <= NCOND'(1) << i;
      tick(6);
      sbc_host_i.rd(A_CODE, d, r);
      hit = 0;
      for (int j = 0; j < 26; j++)
        if (!hit && !used[j] && d[7:0] === ex[j]) begin
          hit = 1;
          used[j] = 1;
        end
      chk("fault code", hit, 1);
    end
    i_cond <= (NCOND'(7) << 26) | (NCOND'(1) << 25) | NCOND'(1);
    tick(6);
    sbc_host_i.rd(A_CODE, d, r);
    chk("red first", d[7:6], C_R);
    i_cond <= (NCOND'(7) << 26) | (NCOND'(1) << 17);
    tick(6);
    sbc_host_i.rd(A_CODE, d, r);
    chk("yellow first", d[7:6], C_Y);
    i_cond <= NCOND'(1) << 26;
    tick(6);
    code_is(8'h7F);
    i_cond <= NCOND'(1) << 27;
    tick(6);
    code_is(8'h75);
    chk("test oos", o_out_of_service, 1);
    i_cond <= NCOND'(1) << 29;
    tick(6);
    code_is(8'h66);
    i_cond <= NCOND'(1) << 28;
    tick(6);
    code_is(8'h66);
    chk("pos hold", o_pos_hold, 1);
    s = 8'h00;
    last = 2'h0;
    // alternating code, so merged flashes cannot hide a reorder
    for (int c = 0; c < 80; c++) begin
      @(negedge i_clock);
      if (o_led !== 2'h0 && o_led !== last) begin
        s = {s[5:0], o_led};
        last = o_led;
      end
    end
    chk("flash order", s == 8'h66 || s == 8'h99, 1);
    i_cond <= '0;
    $display("test faults done");
  endtask

  initial begin
    tick(4);
    i_rst_n <= 1'b1;
    t_init();
    t_shutoff();
    t_source();
    t_squawk();
    t_lock();
    t_cal();
    t_jog();
    t_faults();
    wrap_up();
  end
endmodule
